// >>> logic/lvs_vertical_size.sv
`timescale 1ns/1ps
`include "lvs_defs.svh"


module lvs_vertical_size (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire lvs_pkg::lvs_io_req_t io_req,
  input  wire logic                 vsync_start,
  input  wire logic                 hde_start,
  input  wire logic                 dual_scan_mode,
  input  wire logic [8:0]           line_sync_coarse_start,
  output logic      [7:0]           io_rdata_q,
  output logic                      io_rdata_valid_q,
  output logic                      panel_line_sync_q,
  output logic                      upper_half_q,
  output logic                      lower_half_q,
  output logic                      frame_active_q,
  output logic                      frame_done_q,
  output logic      [10:0]          line_index_q,
  output logic      [10:0]          total_lines_q,
  output logic      [9:0]           upper_lines_q
);

  import lvs_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]    index_q;
  logic [7:0]    sync_size_ext_q;
  logic [7:0]    upper_half_lines_q;
  logic [7:0]    panel_total_lines_q;
  logic          data_wr;
  logic          data_rd;
  logic          index_wr;
  logic [7:0]    rd_mux;

  // ----------------------------------------------------------------
  // Assembled geometry
  // ----------------------------------------------------------------
  logic [9:0]    total_raw;
  logic [8:0]    upper_raw;
  logic [1:0]    fine_delay;
  logic [10:0]   total_lines_d;
  logic [10:0]   upper_lines_d;

  // ----------------------------------------------------------------
  // Frame walker
  // ----------------------------------------------------------------
  lvs_vert_cfg_t cfg_q;
  lvs_vstate_t   state_q;
  lvs_vstate_t   state_d;
  logic [10:0]   line_next;
  logic [10:0]   frame_total;
  logic [10:0]   frame_upper;
  logic          hit_upper;
  logic          hit_total;

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  assign index_wr = io_req.wr && !io_req.data_port;
  assign data_wr  = io_req.wr && io_req.data_port;
  assign data_rd  = io_req.rd && io_req.data_port;

  // ----------------------------------------------------------------
  // Index register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      index_q <= `LVS_RST_INDEX;
    end else if (index_wr) begin
      index_q <= io_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Extension register: only defined bits hold state
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_size_ext_q <= `LVS_RST_SYNC_SIZE_EXT;
    end else if (data_wr && (index_q == `LVS_IDX_SYNC_SIZE_EXT)) begin
      sync_size_ext_q <= io_req.wdata & `LVS_EXT_DEFINED_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Upper-half size register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      upper_half_lines_q <= `LVS_RST_UPPER_HALF;
    end else if (data_wr && (index_q == `LVS_IDX_UPPER_HALF)) begin
      upper_half_lines_q <= io_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Total size register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      panel_total_lines_q <= `LVS_RST_PANEL_TOTAL;
    end else if (data_wr && (index_q == `LVS_IDX_PANEL_TOTAL)) begin
      panel_total_lines_q <= io_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Indices outside this block read as zero; reserved bits were never stored
  always_comb begin
    if (!io_req.data_port) begin
      rd_mux = index_q;
    end else if (index_q == `LVS_IDX_SYNC_SIZE_EXT) begin
      rd_mux = sync_size_ext_q;
    end else if (index_q == `LVS_IDX_UPPER_HALF) begin
      rd_mux = upper_half_lines_q;
    end else if (index_q == `LVS_IDX_PANEL_TOTAL) begin
      rd_mux = panel_total_lines_q;
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_rdata_q       <= 8'h00;
      io_rdata_valid_q <= 1'b0;
    end else if (io_req.rd) begin
      io_rdata_q       <= rd_mux;
      io_rdata_valid_q <= 1'b1;
    end else begin
      io_rdata_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Field assembly
  // ----------------------------------------------------------------
  always_comb begin
    total_raw = {sync_size_ext_q[`LVS_EXT_TOTAL_MSB:`LVS_EXT_TOTAL_LSB], panel_total_lines_q};
    upper_raw = {sync_size_ext_q[`LVS_EXT_UPPER_BIT], upper_half_lines_q};
    fine_delay = sync_size_ext_q[`LVS_EXT_FINE_MSB:`LVS_EXT_FINE_LSB];
    total_lines_d = {1'b0, total_raw} + `LVS_TOTAL_EXTRA_LINES;
    upper_lines_d = {2'b00, upper_raw} + `LVS_UPPER_EXTRA_LINES;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      total_lines_q <= 11'h000;
      upper_lines_q <= 10'h000;
    end else begin
      total_lines_q <= total_lines_d;
      upper_lines_q <= upper_lines_d[9:0];
    end
  end

  // ----------------------------------------------------------------
  // Frame geometry latch
  // ----------------------------------------------------------------
  // Sampled at the vertical pulse so that a write during a frame takes effect next frame
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_q <= '0;
    end else if (vsync_start) begin
      cfg_q.total_raw <= total_raw;
      cfg_q.upper_raw <= upper_raw;
      cfg_q.dual_scan <= dual_scan_mode;
    end
  end

  always_comb begin
    frame_total = {1'b0, cfg_q.total_raw} + `LVS_TOTAL_EXTRA_LINES;
    frame_upper = {2'b00, cfg_q.upper_raw} + `LVS_UPPER_EXTRA_LINES;
    line_next   = line_index_q + 11'h001;
    hit_upper   = cfg_q.dual_scan && (line_next == frame_upper);
    hit_total   = (line_next == frame_total);
  end

  // ----------------------------------------------------------------
  // Frame walker next state
  // ----------------------------------------------------------------
  // The upper and lower halves are not checked for equal size; software keeps them matched
  always_comb begin
    state_d = state_q;
    case (state_q)
      LVS_ST_IDLE: begin
        state_d = LVS_ST_IDLE;
      end
      LVS_ST_FIRST: begin
        if (hde_start && hit_total) begin
          state_d = LVS_ST_IDLE;
        end else if (hde_start && hit_upper) begin
          state_d = LVS_ST_SECOND;
        end
      end
      LVS_ST_SECOND: begin
        if (hde_start && hit_total) begin
          state_d = LVS_ST_IDLE;
        end
      end
      default: begin
        state_d = LVS_ST_IDLE;
      end
    endcase
    if (vsync_start) begin
      state_d = LVS_ST_FIRST;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= LVS_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Line position from the latest vertical pulse
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      line_index_q <= 11'h000;
    end else if (vsync_start) begin
      line_index_q <= 11'h000;
    end else if (hde_start && (state_q != LVS_ST_IDLE)) begin
      if (hit_total) begin
        line_index_q <= 11'h000;
      end else begin
        line_index_q <= line_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      upper_half_q   <= 1'b0;
      lower_half_q   <= 1'b0;
      frame_active_q <= 1'b0;
    end else begin
      upper_half_q   <= (state_d == LVS_ST_FIRST) && cfg_d_dual(vsync_start, dual_scan_mode, cfg_q.dual_scan);
      lower_half_q   <= (state_d == LVS_ST_SECOND);
      frame_active_q <= (state_d != LVS_ST_IDLE);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frame_done_q <= 1'b0;
    end else begin
      frame_done_q <= !vsync_start && hde_start && hit_total && (state_q != LVS_ST_IDLE);
    end
  end

  // Dual-scan flag as it will stand in the frame latch after this edge
  function automatic logic cfg_d_dual(input logic vs, input logic mode, input logic held);
    cfg_d_dual = vs ? mode : held;
  endfunction

  // ----------------------------------------------------------------
  // Active panel line sync
  // ----------------------------------------------------------------
  // Sync repeats every line, also outside the frame, since panels expect a steady line rate
  lvs_line_sync u_line_sync (
    .sys_clk                (sys_clk),
    .reset                  (reset),
    .hde_start              (hde_start),
    .line_sync_coarse_start (line_sync_coarse_start),
    .fine_delay             (fine_delay),
    .panel_line_sync_q      (panel_line_sync_q)
  );

endmodule

// >>> common/lvs_defs.svh
`ifndef LVS_DEFS_SVH
`define LVS_DEFS_SVH

// ----------------------------------------------------------------
// Register indices behind the indexed data port
// ----------------------------------------------------------------
`define LVS_IDX_SYNC_SIZE_EXT   8'h48
`define LVS_IDX_UPPER_HALF      8'h49
`define LVS_IDX_PANEL_TOTAL     8'h4a

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LVS_RST_SYNC_SIZE_EXT   8'h00
`define LVS_RST_UPPER_HALF      8'h00
`define LVS_RST_PANEL_TOTAL     8'h00
`define LVS_RST_INDEX           8'h00

// ----------------------------------------------------------------
// Extension register field positions
// ----------------------------------------------------------------
`define LVS_EXT_TOTAL_MSB       5
`define LVS_EXT_TOTAL_LSB       4
`define LVS_EXT_UPPER_BIT       2
`define LVS_EXT_FINE_MSB        1
`define LVS_EXT_FINE_LSB        0
`define LVS_EXT_DEFINED_MASK    8'h37

// ----------------------------------------------------------------
// Line offsets and timing counts
// ----------------------------------------------------------------
`define LVS_TOTAL_EXTRA_LINES   11'h002
`define LVS_UPPER_EXTRA_LINES   11'h001
`define LVS_COARSE_STEP_SHIFT   2
`define LVS_SYNC_WIDTH_CLKS     4'h8

`endif

// >>> common/lvs_pkg.sv
`include "lvs_defs.svh"

package lvs_pkg;

  // ----------------------------------------------------------------
  // Indexed I/O access, one request per cycle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       data_port;
    logic [7:0] wdata;
  } lvs_io_req_t;

  // ----------------------------------------------------------------
  // Vertical geometry latched for one frame
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] total_raw;
    logic [8:0] upper_raw;
    logic       dual_scan;
  } lvs_vert_cfg_t;

  // ----------------------------------------------------------------
  // Frame walker states, Gray along idle, first, second
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LVS_ST_IDLE   = 2'b00,
    LVS_ST_FIRST  = 2'b01,
    LVS_ST_SECOND = 2'b11
  } lvs_vstate_t;

endpackage

// >>> logic/lvs_line_sync.sv
`timescale 1ns/1ps
`include "lvs_defs.svh"

module lvs_line_sync (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       hde_start,
  input  wire logic [8:0] line_sync_coarse_start,
  input  wire logic [1:0] fine_delay,
  output logic            panel_line_sync_q
);

  // ----------------------------------------------------------------
  // Delay target
  // ----------------------------------------------------------------
  logic [10:0] target_d;
  logic [10:0] target_q;
  logic [10:0] cnt_q;
  logic        run_q;
  logic [3:0]  width_q;
  logic        fire;

  // Coarse steps of four dot clocks plus the fine delay
  always_comb begin
    target_d = {line_sync_coarse_start, 2'b00} + {9'h000, fine_delay};
  end

  assign fire = run_q && (cnt_q == target_q);

  // ----------------------------------------------------------------
  // Dot clock counter from the display window start
  // ----------------------------------------------------------------
  // Target is sampled at the window start so a register write mid-line cannot move the edge twice
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      target_q <= 11'h000;
      cnt_q    <= 11'h000;
      run_q    <= 1'b0;
    end else if (hde_start) begin
      target_q <= target_d;
      cnt_q    <= 11'h000;
      run_q    <= 1'b1;
    end else if (fire) begin
      run_q    <= 1'b0;
    end else if (run_q) begin
      cnt_q    <= cnt_q + 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Sync pulse of fixed width
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      panel_line_sync_q <= 1'b0;
      width_q           <= 4'h0;
    end else if (fire) begin
      panel_line_sync_q <= 1'b1;
      width_q           <= `LVS_SYNC_WIDTH_CLKS - 4'h1;
    end else if (width_q != 4'h0) begin
      width_q           <= width_q - 4'h1;
    end else begin
      panel_line_sync_q <= 1'b0;
    end
  end

endmodule

// >>> test/lvs_vertical_size_checker.sv
`timescale 1ns/1ps

module lvs_vertical_size_checker (
  input wire logic                 sys_clk,
  input wire logic                 reset,
  input wire lvs_pkg::lvs_io_req_t io_req,
  input wire logic                 vsync_start,
  input wire logic                 hde_start,
  input wire logic                 io_rdata_valid_q,
  input wire logic                 panel_line_sync_q,
  input wire logic                 upper_half_q,
  input wire logic                 lower_half_q,
  input wire logic                 frame_active_q,
  input wire logic                 frame_done_q,
  input wire logic [10:0]          line_index_q,
  input wire logic [10:0]          total_lines_q,
  input wire logic [9:0]           upper_lines_q
);
  import lvs_pkg::*;

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_rd_answer: assert property (io_req.rd |=> io_rdata_valid_q)
    else $error("read strobe not answered");
  a_valid_cause: assert property (io_rdata_valid_q |-> $past(io_req.rd))
    else $error("read valid without strobe");
  a_total_floor: assert property (!$past(reset) |-> total_lines_q >= 11'h002)
    else $error("total lines below two");
  a_upper_range: assert property (!$past(reset) |-> upper_lines_q >= 10'h001 && upper_lines_q <= 10'h200)
    else $error("upper lines out of range");
  a_vsync_restart: assert property (vsync_start |=> frame_active_q && line_index_q == 11'h000)
    else $error("vertical pulse did not restart frame");
  a_frame_done: assert property (frame_done_q |-> !frame_active_q && line_index_q == 11'h000 && $past(hde_start))
    else $error("frame end malformed");
  a_half_switch: assert property ($fell(upper_half_q) && frame_active_q && !$past(vsync_start) |-> lower_half_q && line_index_q == {1'b0, upper_lines_q})
    else $error("half switch at wrong line");
  a_half_excl: assert property (upper_half_q |-> frame_active_q && !lower_half_q)
    else $error("upper half outside frame");
  a_sync_width: assert property ($rose(panel_line_sync_q) |-> panel_line_sync_q [*8] ##1 !panel_line_sync_q)
    else $error("line sync width wrong");
  a_idle_index: assert property (!frame_active_q |-> line_index_q == 11'h000)
    else $error("line index moves while idle");
endmodule

bind lvs_vertical_size lvs_vertical_size_checker chk_u (
  .sys_clk, .reset, .io_req, .vsync_start, .hde_start, .io_rdata_valid_q, .panel_line_sync_q,
  .upper_half_q, .lower_half_q, .frame_active_q, .frame_done_q, .line_index_q, .total_lines_q,
  .upper_lines_q
);

// >>> test/lvs_panel_model.sv
`timescale 1ns/1ps

module lvs_panel_model (
  input wire logic   sys_clk,
  input wire logic   reset,
  input wire logic   line_sync,
  input wire logic   upper_half,
  input wire logic   frame_active,
  output logic [10:0] all_cnt,
  output logic [10:0] up_cnt
);
  logic sync_q;
  logic act_q;

  // ----------------------------------------------------------------
  // Lines seen per frame, one per line sync rise
  // ----------------------------------------------------------------
  // A sync that rises after the frame closed belongs to no frame
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_q  <= 1'b0;
      act_q   <= 1'b0;
      all_cnt <= 11'h000;
      up_cnt  <= 11'h000;
    end else begin
      sync_q <= line_sync;
      act_q  <= frame_active;
      if (frame_active && !act_q) begin
        all_cnt <= 11'h000;
        up_cnt  <= 11'h000;
      end else if (line_sync && !sync_q && frame_active) begin
        all_cnt <= all_cnt + 11'h001;
        if (upper_half)
          up_cnt <= up_cnt + 11'h001;
      end
    end
  end
endmodule

// >>> test/testbench.sv
`timescale 1ns/1ps

module testbench;
  import lvs_pkg::*;

  logic        sys_clk, reset, vsync_start, hde_start, dual_scan_mode;
  lvs_io_req_t io_req;
  logic [8:0]  line_sync_coarse_start;
  logic [7:0]  io_rdata_q, ext, up, tot;
  logic        io_rdata_valid_q, panel_line_sync_q, upper_half_q, lower_half_q;
  logic        frame_active_q, frame_done_q;
  logic [10:0] line_index_q, total_lines_q, all_cnt, up_cnt;
  logic [9:0]  upper_lines_q;
  int          n_mismatch, n_checks, n, cnt;

  lvs_vertical_size dut_u (
    .sys_clk, .reset, .io_req, .vsync_start, .hde_start, .dual_scan_mode, .line_sync_coarse_start,
    .io_rdata_q, .io_rdata_valid_q, .panel_line_sync_q, .upper_half_q, .lower_half_q,
    .frame_active_q, .frame_done_q, .line_index_q, .total_lines_q, .upper_lines_q
  );

  lvs_panel_model panel_u (
    .sys_clk, .reset, .line_sync(panel_line_sync_q), .upper_half(upper_half_q),
    .frame_active(frame_active_q), .all_cnt, .up_cnt
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [10:0] exp_tot(input logic [7:0] e, input logic [7:0] t);
    return {1'b0, e[5:4], t} + 11'h002;
  endfunction
  function automatic logic [10:0] exp_up(input logic [7:0] e, input logic [7:0] u);
    return {2'h0, e[2], u} + 11'h001;
  endfunction
  function automatic logic [10:0] exp_delay(input logic [8:0] c, input logic [1:0] f);
    return {c, 2'h0} + {9'h000, f} + 11'h001;
  endfunction

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One-cycle strobe; read answer is looked at one cycle after the strobe
  task automatic io(input logic w, input logic dp, input logic [7:0] d);
    @(negedge sys_clk);
    io_req <= '{wr: w, rd: !w, data_port: dp, wdata: d};
    @(negedge sys_clk);
    io_req <= '0;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    io(1'b1, 1'b0, idx);
    io(1'b1, 1'b1, d);
  endtask
  task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp);
    io(1'b1, 1'b0, idx);
    io(1'b0, 1'b1, 8'h00);
    chk({10'h000, io_rdata_valid_q}, 11'h001);
    chk({3'h0, io_rdata_q}, {3'h0, exp});
  endtask
  task automatic pulse(input logic v);
    @(negedge sys_clk);
    vsync_start <= v;
    hde_start   <= 1'b1;
    @(negedge sys_clk);
    vsync_start <= 1'b0;
    hde_start   <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    io_req = '0;
    vsync_start = 1'b0;
    hde_start = 1'b0;
    dual_scan_mode = 1'b0;
    line_sync_coarse_start = 9'h000;
    void'($urandom(32'hb93b));
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    rd_reg(8'h48, 8'h00);
    rd_reg(8'h49, 8'h00);
    rd_reg(8'h4a, 8'h00);
    chk(total_lines_q, 11'h002);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      ext = (i == 0) ? 8'hff : 8'($urandom);
      up = (i == 0) ? 8'hff : 8'($urandom);
      tot = (i == 0) ? 8'hff : 8'($urandom);
      wr_reg(8'h48, ext);
      wr_reg(8'h49, up);
      wr_reg(8'h4a, tot);
      rd_reg(8'h48, ext & 8'h37);
      rd_reg(8'h49, up);
      rd_reg(8'h4a, tot);
      chk(total_lines_q, exp_tot(ext, tot));
      chk({1'b0, upper_lines_q}, exp_up(ext, up));
    end
    wr_reg(8'h4b, 8'h5a);
    rd_reg(8'h4b, 8'h00);
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      n = 2 * ($urandom % 4);
      wr_reg(8'h48, 8'($urandom % 4));
      wr_reg(8'h49, 8'(n / 2));
      wr_reg(8'h4a, 8'(n));
      line_sync_coarse_start <= 9'($urandom % 4);
      dual_scan_mode <= f[0];
      pulse(1'b1);
      chk({10'h000, frame_active_q}, 11'h001);
      for (int k = 1; k <= n + 2; k++) begin
        repeat (28) @(negedge sys_clk);
        pulse(1'b0);
        chk(line_index_q, 11'(k % (n + 2)));
        chk({10'h000, frame_done_q}, 11'(k == n + 2));
        if (k < n + 2) begin
          chk({10'h000, upper_half_q}, 11'(f[0] && k <= n / 2));
          chk({10'h000, lower_half_q}, 11'(f[0] && k > n / 2));
        end
      end
      repeat (28) @(negedge sys_clk);
      chk(all_cnt, 11'(n + 2));
      chk(up_cnt, f[0] ? 11'(n / 2 + 1) : 11'h000);
    end
    $display("test frames done");
    for (int f = 0; f < 4; f++) begin
      for (int j = 0; j < 3; j++) begin
        ext = 8'(f);
        up = 8'(j);
        wr_reg(8'h48, ext);
        line_sync_coarse_start <= (j == 2) ? 9'h1ff : (j == 1) ? 9'($urandom) : 9'h000;
        pulse(1'b0);
        cnt = 0;
        while (panel_line_sync_q !== 1'b1 && cnt < 2100) begin
          @(negedge sys_clk);
          cnt++;
        end
        if (cnt >= 2100) begin
          n_mismatch++;
          results();
        end
        chk(11'(cnt), exp_delay(line_sync_coarse_start, ext[1:0]));
        repeat (12) @(negedge sys_clk);
      end
    end
    $display("test line sync done");
    results();
  end
endmodule
